// >>> logic/reset_combiner.sv
// reset source combiner with watchdog and illegal fetch detector
`timescale 1ns/1ps
module reset_combiner #(
    parameter bit WATCHDOG_OPTION = 1'b1,
    parameter bit LOW_SUPPLY_OPTION = 1'b1,
    parameter int POWER_UP_CYCLES = reset_pkg::POWER_UP_CYCLES,
    parameter int WATCHDOG_TIMEOUT = reset_pkg::WATCHDOG_TIMEOUT_CYCLES
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // reset pin, open drain
    input wire logic i_reset_pin,
    output logic o_reset_pin,
    output logic o_reset_pin_oe,
    // analog monitors
    input wire logic i_osc_active,
    input wire logic i_supply_above_rearm,
    input wire logic i_low_supply,
    // cpu fetch and mode
    input wire logic i_fetch,
    input wire logic [15:0] i_fetch_addr,
    input wire logic i_user_mode,
    // register port
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_mem_data,
    output logic [7:0] o_rdata,
    // system reset
    output logic o_sys_reset,
    output logic o_sources_any
);
    typedef struct packed {
        reset_pkg::power_up_e pu;
        logic [12:0] pu_cnt;
        logic [16:0] wd_cnt;
        logic wd_fire;
        logic ill_fire;
        logic [2:0] stretch;
        logic prev_ext;
        logic sys_reset;
        logic [7:0] rdata;
    } state_s;

    state_s cur;
    state_s next_cur;
    reset_pkg::sources_s src;
    logic illegal_hit;
    logic wd_clear;
    logic internal_any;

    always_comb begin
        illegal_hit = i_fetch && (
            (i_fetch_addr <= reset_pkg::IO_HI) ||
            (i_fetch_addr >= reset_pkg::GAP1_LO && i_fetch_addr <= reset_pkg::GAP1_HI) ||
            (i_fetch_addr >= reset_pkg::GAP2_LO && i_fetch_addr <= reset_pkg::GAP2_HI) ||
            (i_fetch_addr >= reset_pkg::MON_LO && i_fetch_addr <= reset_pkg::MON_HI));
        wd_clear = i_wr && (i_addr == reset_pkg::WATCHDOG_CLEAR_ADDR)
            && !i_wdata[reset_pkg::WATCHDOG_CLEAR_BIT];
        src.pin_low = !i_reset_pin;
        src.power_up = (cur.pu != reset_pkg::PU_DONE);
        src.watchdog = cur.wd_fire;
        src.illegal = cur.ill_fire;
        src.low_supply = LOW_SUPPLY_OPTION && i_low_supply;
        internal_any = src.power_up | src.watchdog | src.illegal | src.low_supply;
    end

    always_comb begin
        next_cur = cur;
        next_cur.prev_ext = !i_reset_pin;
        next_cur.rdata = reset_pkg::RD_RESET_VALUE;
        if (i_rd) begin
            next_cur.rdata = i_mem_data;
        end
        // power-up sequencer; rearms only on a true supply collapse
        case (cur.pu)
            reset_pkg::PU_WAIT_SUPPLY: begin
                next_cur.pu_cnt = 13'h0000;
                if (i_supply_above_rearm && i_osc_active) begin
                    next_cur.pu = reset_pkg::PU_SETTLE;
                end
            end
            reset_pkg::PU_SETTLE: begin
                next_cur.pu_cnt = cur.pu_cnt + 13'h0001;
                if (cur.pu_cnt == 13'(POWER_UP_CYCLES - 1)) begin
                    next_cur.pu = reset_pkg::PU_DONE;
                end
            end
            reset_pkg::PU_DONE: begin
                next_cur.pu = reset_pkg::PU_DONE;
            end
            default: begin
                next_cur.pu = reset_pkg::PU_WAIT_SUPPLY;
            end
        endcase
        if (!i_supply_above_rearm) begin
            next_cur.pu = reset_pkg::PU_WAIT_SUPPLY;
        end
        // watchdog counts only in user mode while the system reset is released
        if (!WATCHDOG_OPTION || cur.sys_reset || !i_user_mode || wd_clear) begin
            next_cur.wd_cnt = 17'h00000;
            next_cur.wd_fire = 1'b0;
        end else if (cur.wd_cnt == 17'(WATCHDOG_TIMEOUT - 1)) begin
            next_cur.wd_fire = 1'b1;
        end else begin
            next_cur.wd_cnt = cur.wd_cnt + 17'h00001;
        end
        // fire flags clear once the system reset has taken hold
        // the flag itself reloads the stretch, so it must not wait for the stretch to end
        if (cur.sys_reset) begin
            next_cur.ill_fire = 1'b0;
        end else if (illegal_hit && !cur.sys_reset) begin
            next_cur.ill_fire = 1'b1;
        end
        // pulldown stretch of four cycles
        if (internal_any || (src.pin_low && !cur.prev_ext && !o_reset_pin_oe)) begin
            next_cur.stretch = reset_pkg::PIN_STRETCH_CYCLES;
        end else if (cur.stretch != 3'h0) begin
            next_cur.stretch = cur.stretch - 3'h1;
        end
        // or of all sources, release on the clock edge
        next_cur.sys_reset = src.pin_low | internal_any;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            cur <= '0;
            cur.sys_reset <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // pulldown active while any internal source or the stretch runs
    assign o_reset_pin_oe = internal_any || (cur.stretch != 3'h0);
    assign o_reset_pin = 1'b0;
    // mode pins are sampled by the core at this release
    assign o_sys_reset = cur.sys_reset;
    assign o_sources_any = internal_any | src.pin_low;
    assign o_rdata = cur.rdata;

    power_up_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (cur.pu == reset_pkg::PU_SETTLE) |=> o_sys_reset)
        else $error("reset released during power-up settling");
    combine_or_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (src.watchdog || src.illegal || src.low_supply) |=> o_sys_reset)
        else $error("internal source did not assert system reset");
    pin_release_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!internal_any && i_reset_pin) |=> !o_sys_reset)
        else $error("reset not released one cycle after pin high");
    pin_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !i_reset_pin |=> o_sys_reset)
        else $error("pin low did not hold reset");
    pulldown_src_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        internal_any |-> o_reset_pin_oe)
        else $error("pulldown off while source active");
    stretch_len_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $fell(internal_any) |-> o_reset_pin_oe [*3])
        else $error("pulldown stretch shorter than three cycles");
    illegal_fetch_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_fetch && i_fetch_addr == reset_pkg::GAP1_LO && !cur.sys_reset)
        |=> ##1 o_sys_reset)
        else $error("illegal fetch did not reset");
    wd_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        wd_clear |=> (cur.wd_cnt == 17'h00000))
        else $error("watchdog not cleared by write");
    read_mem_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_rd |=> (o_rdata == $past(i_mem_data)))
        else $error("read did not return memory data");

    // shorthands for the checks below
    localparam logic [16:0] WD_LAST = 17'(WATCHDOG_TIMEOUT - 1);
    localparam logic [12:0] PU_LAST = 13'(POWER_UP_CYCLES - 1);
    logic wd_runs;
    assign wd_runs = WATCHDOG_OPTION && !cur.sys_reset && i_user_mode && !wd_clear;

    // combining and release
    sys_hold_src_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_sources_any |=> o_sys_reset)
        else $error("system reset missed an active source");
    sys_release_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !o_sources_any |=> !o_sys_reset)
        else $error("system reset held with no source");
    pin_source_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !i_reset_pin |-> o_sources_any)
        else $error("low pin not counted as a source");
    internal_source_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        internal_any |-> o_sources_any)
        else $error("internal source not counted");
    sys_rise_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $rose(o_sys_reset) |-> $past(o_sources_any))
        else $error("system reset rose without a source");
    sys_fall_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $fell(o_sys_reset) |-> !$past(o_sources_any))
        else $error("system reset fell while a source was active");

    // reset pin driver
    pin_zero_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_reset_pin == 1'b0)
        else $error("reset pin driven high");
    oe_idle_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!internal_any && cur.stretch == 3'h0) |-> !o_reset_pin_oe)
        else $error("pulldown on with nothing to hold");
    oe_stretch_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (cur.stretch != 3'h0) |-> o_reset_pin_oe)
        else $error("pulldown off during stretch");
    ext_low_track_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !i_reset_pin |=> cur.prev_ext)
        else $error("pin history missed a low level");
    ext_high_track_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_reset_pin |=> !cur.prev_ext)
        else $error("pin history missed a high level");
    ext_load_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!i_reset_pin && !cur.prev_ext && !o_reset_pin_oe)
        |=> (cur.stretch == reset_pkg::PIN_STRETCH_CYCLES))
        else $error("external fall did not load the stretch");
    ext_no_retrigger_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!i_reset_pin && cur.prev_ext && !internal_any && cur.stretch == 3'h0)
        |=> (cur.stretch == 3'h0))
        else $error("held pin retriggered the stretch");
    ext_stretch_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!i_reset_pin && !cur.prev_ext && !o_reset_pin_oe) |=> o_reset_pin_oe [*4])
        else $error("external pulldown shorter than four cycles");

    // stretch counter
    stretch_max_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        cur.stretch <= reset_pkg::PIN_STRETCH_CYCLES)
        else $error("stretch above its load value");
    stretch_load_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        internal_any |=> (cur.stretch == reset_pkg::PIN_STRETCH_CYCLES))
        else $error("internal source did not load the stretch");
    stretch_count_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!internal_any && cur.stretch != 3'h0) |=> (cur.stretch == $past(cur.stretch) - 3'h1))
        else $error("stretch did not count down");
    stretch_rest_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!internal_any && cur.stretch == 3'h0 && !(!i_reset_pin && !cur.prev_ext))
        |=> (cur.stretch == 3'h0))
        else $error("stretch started without a cause");
    low_stretch_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (LOW_SUPPLY_OPTION && i_low_supply)
        |=> (cur.stretch == reset_pkg::PIN_STRETCH_CYCLES))
        else $error("low supply did not load the stretch");

    // watchdog
    wd_count_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (wd_runs && cur.wd_cnt != WD_LAST) |=> (cur.wd_cnt == $past(cur.wd_cnt) + 17'h00001))
        else $error("watchdog did not advance");
    wd_max_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        cur.wd_cnt <= WD_LAST)
        else $error("watchdog counter beyond timeout");
    wd_fire_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (wd_runs && cur.wd_cnt == WD_LAST) |=> cur.wd_fire)
        else $error("watchdog did not fire at timeout");
    wd_early_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (cur.wd_cnt != WD_LAST && !cur.wd_fire) |=> !cur.wd_fire)
        else $error("watchdog fired early");
    wd_fire_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (cur.wd_fire && wd_runs) |=> cur.wd_fire)
        else $error("watchdog fire dropped before reset");
    wd_reset_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        cur.wd_fire |=> o_sys_reset)
        else $error("watchdog fire did not reset");
    wd_in_reset_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        cur.sys_reset |=> (cur.wd_cnt == 17'h00000 && !cur.wd_fire))
        else $error("watchdog ran during reset");
    wd_user_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !i_user_mode |=> !cur.wd_fire)
        else $error("watchdog fired outside user mode");
    wd_option_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !WATCHDOG_OPTION |-> !cur.wd_fire)
        else $error("watchdog fired while built out");
    wd_clear_fire_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        wd_clear |=> !cur.wd_fire)
        else $error("clear write left the watchdog fired");
    wd_bit_one_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_wr && i_addr == reset_pkg::WATCHDOG_CLEAR_ADDR && i_wdata[0]
        && wd_runs && cur.wd_cnt != WD_LAST) |=> (cur.wd_cnt != 17'h00000))
        else $error("writing one cleared the watchdog");
    wd_other_addr_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_wr && i_addr != reset_pkg::WATCHDOG_CLEAR_ADDR && wd_runs && cur.wd_cnt != WD_LAST)
        |=> (cur.wd_cnt != 17'h00000))
        else $error("write elsewhere cleared the watchdog");
    wd_read_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_rd && !i_wr && wd_runs && cur.wd_cnt != WD_LAST) |=> (cur.wd_cnt != 17'h00000))
        else $error("read cleared the watchdog");

    // illegal fetch detector
    ill_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (illegal_hit && !cur.sys_reset) |=> cur.ill_fire)
        else $error("illegal fetch not flagged");
    ill_quiet_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!illegal_hit && !cur.ill_fire) |=> !cur.ill_fire)
        else $error("illegal flag set without a fetch");
    ill_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (cur.ill_fire && !cur.sys_reset) |=> cur.ill_fire)
        else $error("illegal flag dropped before reset");
    ill_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (cur.ill_fire && cur.sys_reset) |=> !cur.ill_fire)
        else $error("illegal flag stuck in reset");
    ill_in_reset_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (cur.sys_reset && !cur.ill_fire) |=> !cur.ill_fire)
        else $error("fetch flagged during reset");
    ill_reset_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        cur.ill_fire |=> o_sys_reset)
        else $error("illegal flag did not reset");
    io_fetch_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_fetch && i_fetch_addr <= reset_pkg::IO_HI && !cur.sys_reset) |=> cur.ill_fire)
        else $error("io space fetch not flagged");
    mon_fetch_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_fetch && i_fetch_addr >= reset_pkg::MON_LO && i_fetch_addr <= reset_pkg::MON_HI
        && !cur.sys_reset) |=> cur.ill_fire)
        else $error("monitor fetch not flagged");
    gap1_fetch_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_fetch && i_fetch_addr >= reset_pkg::GAP1_LO && i_fetch_addr <= reset_pkg::GAP1_HI
        && !cur.sys_reset) |=> cur.ill_fire)
        else $error("first gap fetch not flagged");
    gap2_fetch_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_fetch && i_fetch_addr >= reset_pkg::GAP2_LO && i_fetch_addr <= reset_pkg::GAP2_HI
        && !cur.sys_reset) |=> cur.ill_fire)
        else $error("second gap fetch not flagged");
    ram_fetch_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_fetch && i_fetch_addr > reset_pkg::IO_HI && i_fetch_addr < reset_pkg::GAP1_LO
        && !cur.ill_fire) |=> !cur.ill_fire)
        else $error("legal low fetch flagged");
    mid_fetch_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_fetch && i_fetch_addr > reset_pkg::GAP1_HI && i_fetch_addr < reset_pkg::GAP2_LO
        && !cur.ill_fire) |=> !cur.ill_fire)
        else $error("legal middle fetch flagged");
    rom_fetch_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_fetch && i_fetch_addr > reset_pkg::GAP2_HI && i_fetch_addr < reset_pkg::MON_LO
        && !cur.ill_fire) |=> !cur.ill_fire)
        else $error("legal program fetch flagged");
    vector_fetch_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_fetch && i_fetch_addr > reset_pkg::MON_HI && !cur.ill_fire) |=> !cur.ill_fire)
        else $error("legal top fetch flagged");

    // power-up sequencer
    pu_legal_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        cur.pu inside {reset_pkg::PU_WAIT_SUPPLY, reset_pkg::PU_SETTLE, reset_pkg::PU_DONE})
        else $error("power-up state out of range");
    pu_wait_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (cur.pu == reset_pkg::PU_WAIT_SUPPLY && !(i_supply_above_rearm && i_osc_active))
        |=> (cur.pu == reset_pkg::PU_WAIT_SUPPLY))
        else $error("settling began without supply and oscillator");
    pu_start_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (cur.pu == reset_pkg::PU_WAIT_SUPPLY && i_supply_above_rearm && i_osc_active)
        |=> (cur.pu == reset_pkg::PU_SETTLE))
        else $error("settling did not begin");
    pu_zero_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (cur.pu == reset_pkg::PU_WAIT_SUPPLY) |=> (cur.pu_cnt == 13'h0000))
        else $error("settle count not cleared while waiting");
    pu_count_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (cur.pu == reset_pkg::PU_SETTLE && i_supply_above_rearm && cur.pu_cnt != PU_LAST)
        |=> (cur.pu == reset_pkg::PU_SETTLE && cur.pu_cnt == $past(cur.pu_cnt) + 13'h0001))
        else $error("settle count did not advance");
    pu_limit_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (cur.pu == reset_pkg::PU_SETTLE) |-> (cur.pu_cnt <= PU_LAST))
        else $error("settle count beyond its end");
    pu_end_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (cur.pu == reset_pkg::PU_SETTLE && i_supply_above_rearm && cur.pu_cnt == PU_LAST)
        |=> (cur.pu == reset_pkg::PU_DONE))
        else $error("settling did not end on time");
    pu_reset_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (cur.pu != reset_pkg::PU_DONE) |=> o_sys_reset)
        else $error("reset released before power-up done");
    pu_pin_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (cur.pu != reset_pkg::PU_DONE) |-> o_reset_pin_oe)
        else $error("power-up left the pin undriven");
    pu_no_dip_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (cur.pu == reset_pkg::PU_DONE && i_supply_above_rearm)
        |=> (cur.pu == reset_pkg::PU_DONE))
        else $error("power-up reset answered a dip");
    pu_rearm_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !i_supply_above_rearm |=> (cur.pu == reset_pkg::PU_WAIT_SUPPLY))
        else $error("power-up did not rearm on collapse");

    // low supply
    low_pin_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (LOW_SUPPLY_OPTION && i_low_supply) |-> o_reset_pin_oe)
        else $error("low supply left the pin undriven");
    low_reset_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (LOW_SUPPLY_OPTION && i_low_supply) |=> o_sys_reset)
        else $error("low supply did not reset");
    low_option_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !LOW_SUPPLY_OPTION |-> !src.low_supply)
        else $error("low supply active while built out");

    // read port
    read_idle_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !i_rd |=> (o_rdata == reset_pkg::RD_RESET_VALUE))
        else $error("read data outside its cycle");
endmodule

// >>> inc/reset_pkg.sv
// constants and carrier types for the reset source combiner
package reset_pkg;
    localparam logic [15:0] WATCHDOG_CLEAR_ADDR = 16'h3ff0;
    localparam int WATCHDOG_CLEAR_BIT = 0;
    localparam logic [15:0] IO_LO = 16'h0000;
    localparam logic [15:0] IO_HI = 16'h004f;
    localparam logic [15:0] GAP1_LO = 16'h0150;
    localparam logic [15:0] GAP1_HI = 16'h03ff;
    localparam logic [15:0] GAP2_LO = 16'h0500;
    localparam logic [15:0] GAP2_HI = 16'h0fff;
    localparam logic [15:0] MON_LO = 16'h3f00;
    localparam logic [15:0] MON_HI = 16'h3fef;
    localparam int POWER_UP_CYCLES = 4064;
    localparam logic [2:0] PIN_STRETCH_CYCLES = 3'h4;
    localparam int WATCHDOG_TIMEOUT_CYCLES = 65536;
    localparam logic [7:0] RD_RESET_VALUE = 8'h00;

    typedef enum logic [1:0] {
        PU_WAIT_SUPPLY = 2'b00,
        PU_SETTLE = 2'b01,
        PU_DONE = 2'b11
    } power_up_e;

    typedef struct packed {
        logic pin_low;
        logic power_up;
        logic watchdog;
        logic illegal;
        logic low_supply;
    } sources_s;
endpackage

// >>> verification/reset_pin_partner.sv
// far side of the reset pin: board pullup plus an external push switch
`timescale 1ns/1ps
module reset_pin_partner (
    // parties pulling the wire low
    input wire logic i_pulldown_oe,
    input wire logic i_switch_low,
    // resolved wire level
    output logic o_level
);
    // the pullup wins only while nobody pulls low, so the line never floats
    assign o_level = !(i_pulldown_oe || i_switch_low);
endmodule

// >>> verification/reset_combiner_tb.sv
// self-checking bench for the reset source combiner
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module reset_combiner_tb;
    logic i_clock = 0, i_rst_n = 0, osc = 0, above = 0, low = 0, fetch = 0, user = 0;
    logic [15:0] faddr = 0, addr = 0;
    logic [7:0] wdata = 0, mem = 0, rdata;
    logic wr = 0, rd = 0, sw = 0, pin, oe, pin_drv, sys, any;
    int n_errors = 0, total_checks = 0;
    logic [31:0] seed = 32'hbcef0d02;
    always #12.5 i_clock = ~i_clock;
    reset_combiner #(.POWER_UP_CYCLES(16), .WATCHDOG_TIMEOUT(64)) reset_combiner_i (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_reset_pin(pin), .o_reset_pin(pin_drv),
        .o_reset_pin_oe(oe), .i_osc_active(osc), .i_supply_above_rearm(above),
        .i_low_supply(low), .i_fetch(fetch), .i_fetch_addr(faddr), .i_user_mode(user),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_mem_data(mem),
        .o_rdata(rdata), .o_sys_reset(sys), .o_sources_any(any));
    reset_pin_partner reset_pin_partner_i (.i_pulldown_oe(oe), .i_switch_low(sw), .o_level(pin));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    function automatic logic bad(input logic [15:0] a);
        return a <= reset_pkg::IO_HI || (a >= reset_pkg::GAP1_LO && a <= reset_pkg::GAP1_HI)
            || (a >= reset_pkg::GAP2_LO && a <= reset_pkg::GAP2_HI)
            || (a >= reset_pkg::MON_LO && a <= reset_pkg::MON_HI);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task automatic wait_sys(input logic v, input int n);
        for (int k = 0; k < n && sys !== v; k++) tick(1);
        `CHK(sys, v)
    endtask
    task automatic wr_clr(input logic [7:0] d);
        @(posedge i_clock);
        wr <= 1;
        addr <= reset_pkg::WATCHDOG_CLEAR_ADDR;
        wdata <= d;
        @(posedge i_clock);
        wr <= 0;
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    logic [15:0] corner [10] = '{16'h0000, 16'h004f, 16'h0150, 16'h03ff, 16'h0500,
        16'h0fff, 16'h3f00, 16'h3fef, 16'h014f, 16'h3ff0};
    initial begin
        tick(3);
        i_rst_n <= 1;
        above <= 1;
        osc <= 1;
        tick(10);
        `CHK(sys, 1'b1)
        wait_sys(1'b0, 12);
        user <= 1;
        for (int i = 0; i < 6; i++) begin
            tick(40);
            wr_clr(8'hfe);
        end
        `CHK(sys, 1'b0)
        wr_clr(8'h01);
        wait_sys(1'b1, 75);
        wait_sys(1'b0, 20);
        user <= 0;
        tick(100);
        `CHK(sys, 1'b0)
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            @(posedge i_clock);
            rd <= 1;
            addr <= reset_pkg::WATCHDOG_CLEAR_ADDR;
            mem <= seed[7:0];
            @(posedge i_clock);
            rd <= 0;
            #1 `CHK(rdata, seed[7:0])
        end
        for (int i = 0; i < 30; i++) begin
            seed = xs(seed);
            faddr <= (i < 10) ? corner[i] : seed[15:0] & 16'h3fff;
            @(posedge i_clock);
            fetch <= 1;
            @(posedge i_clock);
            fetch <= 0;
            tick(2);
            `CHK(sys, bad(faddr))
            wait_sys(1'b0, 20);
        end
        low <= 1;
        wait_sys(1'b1, 3);
        `CHK(oe, 1'b1)
        `CHK(any, 1'b1)
        `CHK(pin_drv, 1'b0)
        @(posedge i_clock);
        low <= 0;
        tick(2);
        `CHK(oe, 1'b1)
        wait_sys(1'b0, 10);
        sw <= 1;
        tick(2);
        `CHK(oe, 1'b1)
        `CHK(sys, 1'b1)
        tick(8);
        `CHK(oe, 1'b0)
        sw <= 0;
        wait_sys(1'b0, 3);
        end_of_test();
    end
    initial begin
        #300000;
        n_errors++;
        end_of_test();
    end
endmodule
